// ==== pkg/dass_regs.vh ====
// Overview of operation
// - an alarm on one axis makes the other axis follow it to rest
// - mode digit 0 off, 1 to 3 stop modes; new value used after restart
// - mode 1: position control on follower, target is alarm axis position
// - mode 2: speed control on follower, target is alarm axis speed
// - mode 3: follower goes servo off at once; follower stops by servo-off method, alarm axis by group 2 method
// - mode 3 never sets the stopping status bit
// - while stopping, only emergency commands are accepted
// - stopping ends with servo off, status cleared, on four end causes
// - modes 1,2 end when alarm axis speed below end speed; default 256
// - after stopping ends all host commands are accepted again
// - mode 1 adds speed feedforward 0 to 100 percent, default 80
// - feedforward applies under model following only with its feedforward enabled
// - encoder alarms without position data force servo off, no stopping
// - warning raised when stopping occurs unless mask digit is 8 to F
// - status bit is bit 31 of the io status word; 1 means stopping
// - follower alarm during stopping cancels it; stop by alarm method
// - after stopping, motor state follows configured stop methods
// - group 1 and 2 alarm default stop method is dynamic braking
`ifndef DASS_REGS_VH
`define DASS_REGS_VH
`define DASS_MODE_OFF        2'h0
`define DASS_MODE_POS        2'h1
`define DASS_MODE_SPD        2'h2
`define DASS_MODE_SVOFF      2'h3
`define DASS_END_SPEED_RST   16'h0100
`define DASS_FF_RST          7'h50
`define DASS_FF_MAX          7'h64
`define DASS_STATUS_BIT      31
`define DASS_STOP_DB         4'h0
`define DASS_CYCLE_DIV       8'h64
`define DASS_ALM_LIST_LEN    9
`endif

// ==== hw/dass_cycle_tick.v ====
`timescale 1ns/1ps
`default_nettype none
module dass_cycle_tick #(
  parameter DIV = 100
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // control cycle pulse
  output reg  tick_r
);
  // terminal count kept at counter width on purpose
  localparam [15:0] DIV_M1 = DIV - 1;
  reg [15:0] cnt_r;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (cnt_r == DIV_M1) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hw/dass_enc_alarm_chk.v ====
`timescale 1ns/1ps
`default_nettype none
module dass_enc_alarm_chk (
  // alarm code
  input  wire [11:0] alarm_code,
  // code leaves no valid position
  output wire        no_pos_data
);
  // nine encoder alarm codes, fixed table
  wire [11:0] tbl [0:8];
  assign tbl[0] = 12'h810;
  assign tbl[1] = 12'h820;
  assign tbl[2] = 12'h840;
  assign tbl[3] = 12'h850;
  assign tbl[4] = 12'h890;
  assign tbl[5] = 12'h891;
  assign tbl[6] = 12'hC90;
  assign tbl[7] = 12'hC91;
  assign tbl[8] = 12'hC92;
  wire [8:0] hit;
  genvar i;
  generate
    for (i = 0; i < 9; i = i + 1) begin : g_cmp
      assign hit[i] = (alarm_code == tbl[i]);
    end
  endgenerate
  assign no_pos_data = |hit;
endmodule
`default_nettype wire

// ==== hw/dass_sync_stop.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dass_regs.vh"
module dass_sync_stop #(
  parameter PW       = 32,
  parameter SW       = 32,
  parameter CYC_DIV  = 100
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // configuration
  input  wire [1:0]    sync_stop_mode_select,
  input  wire [15:0]   sync_stop_end_speed,
  input  wire [6:0]    sync_stop_speed_feedforward,
  input  wire          model_following_config,
  input  wire          model_following_ff_config,
  input  wire [3:0]    warning_check_mask,
  input  wire [3:0]    servo_off_group1_stop_method,
  input  wire [3:0]    group2_stop_method,
  // axis a
  input  wire          alarm_a,
  input  wire [11:0]   alarm_code_a,
  input  wire          servo_on_a,
  input  wire [PW-1:0] fb_pos_a,
  input  wire [SW-1:0] fb_spd_a,
  // axis b
  input  wire          alarm_b,
  input  wire [11:0]   alarm_code_b,
  input  wire          servo_on_b,
  input  wire [PW-1:0] fb_pos_b,
  input  wire [SW-1:0] fb_spd_b,
  // host commands
  input  wire          host_cmd_valid,
  input  wire          host_cmd_emergency,
  input  wire          servo_off_command,
  input  wire          link_command_a,
  input  wire [30:0]   io_status_low,
  // host command pass-through
  output reg           host_cmd_accept_r,
  output reg           host_cmd_reject_r,
  // follower control
  output reg           follow_a_r,
  output reg           follow_b_r,
  output reg           follow_pos_mode_r,
  output reg           follow_spd_mode_r,
  output reg  [PW-1:0] follow_target_pos_r,
  output reg  [SW-1:0] follow_target_spd_r,
  output reg  [SW-1:0] follow_ff_spd_r,
  output reg           force_servo_off_a_r,
  output reg           force_servo_off_b_r,
  output reg  [3:0]    stop_method_a_r,
  output reg  [3:0]    stop_method_b_r,
  // status
  output reg           sync_stop_warning_r,
  output reg  [31:0]   io_signal_status_word_r
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STOP = 2'h1;
  localparam ST_DONE = 2'h2;

  wire tick;
  wire nopos_a;
  wire nopos_b;
  dass_cycle_tick #(.DIV(CYC_DIV)) u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick_r  (tick)
  );
  dass_enc_alarm_chk u_chk_a (
    .alarm_code  (alarm_code_a),
    .no_pos_data (nopos_a)
  );
  dass_enc_alarm_chk u_chk_b (
    .alarm_code  (alarm_code_b),
    .no_pos_data (nopos_b)
  );

  // mode latched once after reset: restart needed to change it
  reg [1:0]  mode_r;
  reg        mode_ld_r;
  reg [1:0]  st_r;
  reg        lead_b_r;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_r    <= `DASS_MODE_OFF;
      mode_ld_r <= 1'b0;
    end else if (!mode_ld_r) begin
      mode_r    <= sync_stop_mode_select;
      mode_ld_r <= 1'b1;
    end
  end

  wire [PW-1:0] lead_pos = lead_b_r ? fb_pos_b : fb_pos_a;
  wire [SW-1:0] lead_spd = lead_b_r ? fb_spd_b : fb_spd_a;
  wire [SW-1:0] lead_mag = lead_spd[SW-1] ? (~lead_spd + {{(SW-1){1'b0}}, 1'b1}) : lead_spd;
  // end speed in 1000 units/s; compare against scaled threshold
  wire [SW+9:0] end_thr  = {{(SW-6){1'b0}}, sync_stop_end_speed} * 10'd1000;
  wire          below    = {10'h000, lead_mag} < end_thr;
  wire          fol_alm  = lead_b_r ? alarm_a : alarm_b;
  wire          fol_son  = lead_b_r ? servo_on_a : servo_on_b;
  wire          off_cmd  = host_cmd_valid && (servo_off_command || link_command_a);
  wire          ff_ok    = !model_following_config || model_following_ff_config;
  wire [SW+6:0] ff_prod  = $signed({lead_spd[SW-1], lead_spd}) *
                           $signed({1'b0, sync_stop_speed_feedforward});
  wire [SW+6:0] ff_div   = $signed(ff_prod) / $signed(8'sd100);
  wire          any_alm  = alarm_a ^ alarm_b;
  wire          nopos    = alarm_a ? nopos_a : nopos_b;
  reg           in_stop_r;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r                <= ST_IDLE;
      lead_b_r            <= 1'b0;
      in_stop_r           <= 1'b0;
      follow_a_r          <= 1'b0;
      follow_b_r          <= 1'b0;
      follow_pos_mode_r   <= 1'b0;
      follow_spd_mode_r   <= 1'b0;
      follow_target_pos_r <= {PW{1'b0}};
      follow_target_spd_r <= {SW{1'b0}};
      follow_ff_spd_r     <= {SW{1'b0}};
      force_servo_off_a_r <= 1'b0;
      force_servo_off_b_r <= 1'b0;
      sync_stop_warning_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          force_servo_off_a_r <= 1'b0;
          force_servo_off_b_r <= 1'b0;
          if (mode_r != `DASS_MODE_OFF && any_alm) begin
            lead_b_r <= alarm_b;
            if (nopos || mode_r == `DASS_MODE_SVOFF) begin
              // servo off follower, no status bit
              force_servo_off_a_r <= alarm_b;
              force_servo_off_b_r <= alarm_a;
              st_r <= ST_DONE;
            end else begin
              follow_a_r        <= alarm_b;
              follow_b_r        <= alarm_a;
              follow_pos_mode_r <= (mode_r == `DASS_MODE_POS);
              follow_spd_mode_r <= (mode_r == `DASS_MODE_SPD);
              in_stop_r         <= 1'b1;
              st_r              <= ST_STOP;
              if (warning_check_mask < 4'h8) begin
                sync_stop_warning_r <= 1'b1;
              end
            end
          end
        end
        ST_STOP: begin
          follow_target_pos_r <= lead_pos;
          follow_target_spd_r <= lead_spd;
          if (follow_pos_mode_r && ff_ok) begin
            follow_ff_spd_r <= ff_div[SW-1:0];
          end else begin
            follow_ff_spd_r <= {SW{1'b0}};
          end
          // follower alarm cancels and uses its own alarm stop method
          if (fol_alm || !fol_son || off_cmd || (tick && below)) begin
            follow_a_r          <= 1'b0;
            follow_b_r          <= 1'b0;
            follow_pos_mode_r   <= 1'b0;
            follow_spd_mode_r   <= 1'b0;
            follow_ff_spd_r     <= {SW{1'b0}};
            force_servo_off_a_r <= lead_b_r;
            force_servo_off_b_r <= !lead_b_r;
            in_stop_r           <= 1'b0;
            st_r                <= ST_DONE;
          end
        end
        ST_DONE: begin
          // wait for alarms cleared before rearming
          if (!alarm_a && !alarm_b) begin
            force_servo_off_a_r <= 1'b0;
            force_servo_off_b_r <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // status word updated each control cycle
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      io_signal_status_word_r <= 32'h00000000;
    end else if (tick) begin
      io_signal_status_word_r <= {in_stop_r, io_status_low};
    end
  end

  // commands gated while stopping
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      host_cmd_accept_r <= 1'b0;
      host_cmd_reject_r <= 1'b0;
    end else begin
      host_cmd_accept_r <= host_cmd_valid && (!in_stop_r || host_cmd_emergency);
      host_cmd_reject_r <= host_cmd_valid && in_stop_r && !host_cmd_emergency;
    end
  end

  // stop methods follow configuration; reset default is dynamic brake
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stop_method_a_r <= `DASS_STOP_DB;
      stop_method_b_r <= `DASS_STOP_DB;
    end else begin
      stop_method_a_r <= alarm_a ? group2_stop_method : servo_off_group1_stop_method;
      stop_method_b_r <= alarm_b ? group2_stop_method : servo_off_group1_stop_method;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dass_sync_stop_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module dass_sync_stop_checker (
  // clock and settings
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [1:0]  sync_stop_mode_select,
  input wire logic [3:0]  warning_check_mask,
  input wire logic [3:0]  servo_off_group1_stop_method,
  input wire logic [3:0]  group2_stop_method,
  input wire logic        alarm_a,
  input wire logic        servo_on_a,
  input wire logic        host_cmd_valid,
  input wire logic        host_cmd_emergency,
  input wire logic        servo_off_command,
  // watched outputs
  input wire logic        host_cmd_accept_r,
  input wire logic        host_cmd_reject_r,
  input wire logic        follow_a_r,
  input wire logic        follow_b_r,
  input wire logic        sync_stop_warning_r,
  input wire logic [3:0]  stop_method_a_r,
  input wire logic [31:0] io_signal_status_word_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ans; host_cmd_valid |=> host_cmd_accept_r ^ host_cmd_reject_r; endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_emg; host_cmd_valid && host_cmd_emergency |=> host_cmd_accept_r; endproperty
  a_emg: assert property (p_emg) else $error("emergency refused");
  property p_m3s; sync_stop_mode_select == 2'h3 |-> !io_signal_status_word_r[31]; endproperty
  a_m3s: assert property (p_m3s) else $error("status in mode 3");
  property p_m3f; sync_stop_mode_select == 2'h3 |-> !(follow_a_r || follow_b_r); endproperty
  a_m3f: assert property (p_m3f) else $error("follow in mode 3");
  property p_msk; warning_check_mask[3] |-> !sync_stop_warning_r; endproperty
  a_msk: assert property (p_msk) else $error("masked warning shown");
  property p_svo; follow_a_r && !servo_on_a |=> !follow_a_r; endproperty
  a_svo: assert property (p_svo) else $error("follow after servo off");
  property p_off; follow_a_r && host_cmd_valid && servo_off_command |=> !follow_a_r; endproperty
  a_off: assert property (p_off) else $error("follow after off command");
  property p_mth;
    1'b1 |=> stop_method_a_r == ($past(alarm_a) ? $past(group2_stop_method)
                                              : $past(servo_off_group1_stop_method));
  endproperty
  a_mth: assert property (p_mth) else $error("stop method wrong");
  cover property (follow_a_r && io_signal_status_word_r[31]);
  cover property (host_cmd_reject_r);
  cover property (sync_stop_warning_r);
endmodule
bind dass_sync_stop dass_sync_stop_checker i_chk (.*);
`default_nettype wire

// ==== tb/dass_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dass_host_model (
  // clock
  input  wire logic clk_sys,
  // command
  output logic      host_cmd_valid = 1'b0,
  output logic      host_cmd_emergency = 1'b0,
  output logic      servo_off_command = 1'b0,
  output logic      link_command_a = 1'b0,
  // answer
  input  wire logic host_cmd_accept_r
);
  logic acc;
  // pulse for one edge, answer taken at the next
  task send(input logic [2:0] q);
    @(posedge clk_sys);
    host_cmd_valid <= 1'b1;
    {host_cmd_emergency, servo_off_command, link_command_a} <= q;
    @(posedge clk_sys);
    host_cmd_valid <= 1'b0;
    // qualifiers mean nothing once valid drops
    {host_cmd_emergency, servo_off_command, link_command_a} <= ~q;
    #1 acc = host_cmd_accept_r;
  endtask
endmodule
`default_nettype wire

// ==== tb/dual_axis_synchronized_stop_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dass_regs.vh"
module dual_axis_synchronized_stop_tb_top;
  localparam int CD = 4;
  logic        clk_sys = 1'b0, rst_n, alarm_a, alarm_b, servo_on_a, servo_on_b;
  logic        model_following_config = 1'b0, model_following_ff_config = 1'b0;
  logic [1:0]  sync_stop_mode_select;
  logic [15:0] sync_stop_end_speed;
  logic [6:0]  sync_stop_speed_feedforward;
  logic [3:0]  warning_check_mask, servo_off_group1_stop_method, group2_stop_method;
  logic [11:0] alarm_code_a = 12'h000, alarm_code_b;
  logic [31:0] fb_pos_a = 32'h0, fb_spd_a = 32'h0, fb_pos_b, fb_spd_b;
  logic [30:0] io_status_low;
  logic        host_cmd_valid, host_cmd_emergency, servo_off_command, link_command_a;
  logic        host_cmd_accept_r, host_cmd_reject_r, follow_a_r, follow_b_r, follow_pos_mode_r;
  logic        follow_spd_mode_r, force_servo_off_a_r, force_servo_off_b_r, sync_stop_warning_r;
  logic [31:0] follow_target_pos_r, follow_target_spd_r, follow_ff_spd_r, io_signal_status_word_r;
  logic [3:0]  stop_method_a_r, stop_method_b_r;
  logic [11:0] enc [$] = '{12'h810, 12'h820, 12'h840, 12'h850, 12'h890, 12'h891, 12'hC90,
                           12'hC91, 12'hC92};
  int          fails = 0, total_checks = 0, cyc_n = 0, m, sp;
  dass_sync_stop #(.CYC_DIV(CD)) i_dut (.*);
  dass_host_model i_host (.*);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 2000) begin
      fails++;
      end_sim;
    end
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // restart: mode is only taken at restart
  task start(input int md);
    rst_n <= 1'b0;
    sync_stop_mode_select <= 2'(md);
    sync_stop_end_speed <= 16'($urandom_range(65535, 1));
    sync_stop_speed_feedforward <= 7'($urandom_range(100));
    // one method set shared by both axes
    {warning_check_mask, group2_stop_method, servo_off_group1_stop_method} <= 12'($urandom);
    {alarm_a, alarm_b, servo_on_a, servo_on_b} <= 4'h3;
    {alarm_code_b, fb_pos_b, fb_spd_b} <= {12'h510, 32'($urandom), 32'h0};
    io_status_low <= 31'($urandom);
    step(10);
    chk("reset_stop_method", stop_method_a_r, `DASS_STOP_DB);
    @(posedge clk_sys) rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  initial begin
    void'($urandom(47));
    for (int i = 0; i < 7; i++) begin
      m = (i < 5) ? i % 2 + 1 : 3 * (6 - i);
      start(m);
      sp = sync_stop_end_speed * 1000 + 7;
      alarm_b <= 1'b1;
      fb_spd_b <= (m == 2) ? -sp : sp;
      step(2);
      chk("follow_a", follow_a_r, m == 1 || m == 2);
      chk("force_off_a", force_servo_off_a_r, m == 3);
      chk("pos_mode", follow_pos_mode_r, m == 1);
      chk("warning", sync_stop_warning_r, (m == 1 || m == 2) && !warning_check_mask[3]);
      step(CD + 2);
      chk("status", io_signal_status_word_r, {m == 1 || m == 2, io_status_low});
      if (m == 1 || m == 2) begin
        chk("target_pos", follow_target_pos_r, fb_pos_b);
        chk("target_spd", follow_target_spd_r, fb_spd_b);
        if (m == 1)
          chk("ff", follow_ff_spd_r, 32'(longint'(sp) * sync_stop_speed_feedforward / 100));
        i_host.send(3'h0);
        chk("refused", i_host.acc, 1'b0);
        i_host.send(3'h4);
        chk("emergency", i_host.acc, 1'b1);
        @(posedge clk_sys);
        case (i)
          0: fb_spd_b <= sp - 8;
          1: servo_on_a <= 1'b0;
          2: i_host.send(3'h2);
          3: alarm_a <= 1'b1;
          default: i_host.send(3'h1);
        endcase
        step(2 * CD + 3);
        chk("follow_end", follow_a_r, 1'b0);
        chk("status_end", io_signal_status_word_r[31], 1'b0);
        if (i == 3)
          chk("method_a", stop_method_a_r, group2_stop_method);
        else
          chk("off_end", force_servo_off_a_r, 1'b1);
        i_host.send(3'h0);
        chk("after_end", i_host.acc, 1'b1);
      end
    end
    foreach (enc[k]) begin
      start(1);
      {alarm_code_b, alarm_b} <= {enc[k], 1'b1};
      step(2);
      chk("enc_follow", {follow_a_r, force_servo_off_a_r}, 2'h1);
    end
    end_sim;
  end
endmodule
`default_nettype wire
